// File: eep_array.sv
// eep_array: 2048-byte storage in flip-flops, one page programmed per commit.
// assumes the page buffer is stable while commit pulses.
`timescale 1ns/1ps
`default_nettype none
`include "eep_cfg.svh"
module eep_array (
  input  wire logic clk,
  input  wire logic rst_n,
  eep_page_if.mem   pg
);
  logic [7:0] mem [`EEP_MEM_BYTES];

  // ---------------------------------------------------------------------------
  // programming
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `EEP_MEM_BYTES; i++) begin
        mem[i] <= `EEP_ERASED;
      end
    end else if (pg.commit) begin
      for (int j = 0; j < `EEP_PAGE_BYTES; j++) begin
        if (pg.mask[j]) begin
          mem[{pg.base, j[`EEP_PAGE_BITS-1:0]}] <= pg.data[j];
        end
      end
    end
  end

  // array is only changed while reads are refused, so this port is quiet
  assign pg.rd_data = mem[pg.rd_addr];
endmodule : eep_array
`default_nettype wire

// File: eep_cfg.svh
// eep_cfg.svh: offsets, field positions, opcodes, reset values and timing
// for the serial eeprom target; included by eep_pkg and the design modules.
`ifndef EEP_CFG_SVH
`define EEP_CFG_SVH

// ---------------------------------------------------------------------------
// geometry
// ---------------------------------------------------------------------------
`define EEP_ADDR_BITS 11
`define EEP_MEM_BYTES 2048
// 32-byte page; set to 4 and 16 for the small-page variant
`define EEP_PAGE_BITS 5
`define EEP_PAGE_BYTES 32
`define EEP_ERASED 8'hFF

// ---------------------------------------------------------------------------
// opcodes
// ---------------------------------------------------------------------------
`define EEP_OP_READ 8'h03
`define EEP_OP_WRITE 8'h02
`define EEP_OP_CLR_LATCH 8'h04
`define EEP_OP_SET_LATCH 8'h06
`define EEP_OP_STAT_RD 8'h05
`define EEP_OP_STAT_WR 8'h01

// ---------------------------------------------------------------------------
// status byte fields
// ---------------------------------------------------------------------------
`define EEP_ST_BUSY 0
`define EEP_ST_LATCH 1
`define EEP_ST_BP_LO 2
`define EEP_ST_BP_HI 3
`define EEP_ST_PPE 7
`define EEP_STATUS_RST 8'h00

// ---------------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------------
`define EEP_CLK_HZ 10000000
`define EEP_TWC_MS 5
`define EEP_TWC_CYCLES ((`EEP_TWC_MS * `EEP_CLK_HZ) / 1000)

`endif

// File: eep_page_if.sv
// eep_page_if: page buffer, commit strobe and read port between the
// link logic and the array. data/mask/base/rd_addr come from the link
// clock and are only sampled while they stand still.
`timescale 1ns/1ps
`default_nettype none
`include "eep_cfg.svh"
interface eep_page_if;
  logic [7:0]                                 data [`EEP_PAGE_BYTES];
  logic [`EEP_PAGE_BYTES-1:0]                 mask;
  logic [`EEP_ADDR_BITS-1:`EEP_PAGE_BITS]     base;
  logic                                       commit;
  logic [`EEP_ADDR_BITS-1:0]                  rd_addr;
  logic [7:0]                                 rd_data;

  modport link (output data, mask, base, commit, rd_addr, input rd_data);
  modport mem  (input data, mask, base, commit, rd_addr, output rd_data);
endinterface : eep_page_if
`default_nettype wire

// File: eep_pkg.sv
// eep_pkg: types shared by the serial eeprom target modules.
// assumes eep_cfg.svh on the include path.
`default_nettype none
`include "eep_cfg.svh"
package eep_pkg;
  typedef logic [7:0] eep_byte_t;
  typedef logic [`EEP_ADDR_BITS-1:0] eep_addr_t;

  // phase of the link frame; op, address and status-write phases last one byte each
  typedef enum logic [2:0] {
    EEP_PH_OP,
    EEP_PH_AHI,
    EEP_PH_ALO,
    EEP_PH_RD,
    EEP_PH_WR,
    EEP_PH_SRD,
    EEP_PH_SWR,
    EEP_PH_END
  } eep_phase_e;

  // what a frame leaves behind when chip select rises
  typedef enum logic [2:0] {
    EEP_OUT_NONE,
    EEP_OUT_SET,
    EEP_OUT_CLR,
    EEP_OUT_WRITE,
    EEP_OUT_STAT
  } eep_outcome_e;
endpackage : eep_pkg
`default_nettype wire

// File: eep_spi_host.sv
// eep_spi_host: behavioural spi host, sck 160 ns, idle low outside frames.
// assumes so has a pull-up on the wire when the target lets it go.
`timescale 1ns/1ps
`default_nettype none
module eep_spi_host (
  input  wire logic clk,
  input  wire logic so,
  input  wire logic so_oe,
  output var  logic sck,
  output var  logic cs_n,
  output var  logic si,
  output var  logic hold_n
);
  // ---------------------------------------------------------------------
  // frame and byte tasks
  // ---------------------------------------------------------------------
  localparam time HALF = 80ns;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end
  task automatic sel();
    @(negedge clk);
    cs_n = 1'b0;
  endtask : sel
  task automatic desel();
    #(HALF);
    @(negedge clk);
    cs_n = 1'b1;
    si = ~si;
    repeat (8) @(negedge clk);
  endtask : desel
  task automatic xfer(input logic [7:0] tx, input int nb, input int hold_at,
                      output logic [7:0] rx);
    rx = 8'hFF;
    for (int i = 7; i > 7 - nb; i--) begin
      if (i == hold_at) begin
        #20;
        hold_n = 1'b0;
        repeat (3) begin
          #(HALF) sck = 1'b1;
          #(HALF) sck = 1'b0;
        end
        #20;
        hold_n = 1'b1;
      end
      si = tx[i];
      #(HALF);
      sck = 1'b1;
      rx[i] = so_oe ? so : 1'b1;
      #(HALF);
      sck = 1'b0;
    end
  endtask : xfer
endmodule : eep_spi_host
`default_nettype wire

// File: eep_sync.sv
// eep_sync: two flip-flop level synchroniser, one per bit.
// assumes each bit is a level or stands still while it is sampled.
`timescale 1ns/1ps
`default_nettype none
module eep_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : eep_sync
`default_nettype wire

// File: eep_top.sv
// eep_top: spi serial eeprom target, command decode, page write and
// self-timed write cycle. assumes sck, si and hold_n obey spi setup/hold
// around sck edges; cs_n is sampled directly by the link logic.
`timescale 1ns/1ps
`default_nettype none
`include "eep_cfg.svh"
module eep_top #(
  parameter int TWC_CYCLES = `EEP_TWC_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic sck,
  input  wire logic cs_n,
  input  wire logic si,
  input  wire logic hold_n,
  output var  logic so,
  output var  logic so_oe
);
  eep_page_if pg ();

  // ---------------------------------------------------------------------------
  // link side state (sck domain)
  // ---------------------------------------------------------------------------
  eep_pkg::eep_phase_e   phase;
  eep_pkg::eep_outcome_e outcome;
  eep_pkg::eep_byte_t    instr;
  eep_pkg::eep_byte_t    stat_in;
  eep_pkg::eep_addr_t    ptr;
  eep_pkg::eep_byte_t    status_lnk;
  logic [2:0]            bit_cnt;
  logic [6:0]            shift_in;
  logic [6:0]            out_sh;
  logic [2:0]            addr_hi;
  logic [`EEP_PAGE_BITS-1:0] off;
  logic                  fresh;
  logic                  frame_tog;
  logic                  frame_rst;
  logic                  oe_q;
  logic                  step;
  logic                  byte_done;
  eep_pkg::eep_byte_t    rx_byte;
  eep_pkg::eep_byte_t    cur_byte;

  // ---------------------------------------------------------------------------
  // control side state (clk domain)
  // ---------------------------------------------------------------------------
  logic [12:0]           sync_q;
  logic                  cs_s;
  logic                  cs_d;
  logic                  tog_s;
  logic                  tog_seen;
  eep_pkg::eep_outcome_e out_s;
  eep_pkg::eep_byte_t    stat_s;
  logic                  act;
  logic                  start;
  logic                  done;
  logic                  busy;
  logic                  latch;
  logic                  ppe;
  logic                  bp_hi;
  logic                  bp_lo;
  logic [15:0]           tmr;
  eep_pkg::eep_byte_t    status;

  // ---------------------------------------------------------------------------
  // link decode helpers
  // ---------------------------------------------------------------------------
  assign frame_rst = cs_n | ~rst_n;
  assign step      = ~cs_n & hold_n;
  assign byte_done = (bit_cnt == 3'h7);
  assign rx_byte   = {shift_in, si};

  // status byte as seen on the link, busy bit keeps answering
  eep_sync #(.W(8)) u_stat_sync (
    .clk   (sck),
    .rst_n (rst_n),
    .d     (status),
    .q     (status_lnk)
  );

  // ---------------------------------------------------------------------------
  // frame sequencer: bit count, shift, phase
  // ---------------------------------------------------------------------------
  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt  <= 3'h0;
      shift_in <= 7'h00;
      phase    <= eep_pkg::EEP_PH_OP;
      fresh    <= 1'b1;
    end else if (hold_n) begin
      bit_cnt  <= bit_cnt + 3'h1;
      shift_in <= rx_byte[6:0];
      fresh    <= 1'b0;
      if (byte_done) begin
        unique case (phase)
          eep_pkg::EEP_PH_OP: begin
            unique case (rx_byte)
              `EEP_OP_READ,
              `EEP_OP_WRITE: begin
                // array access refused while programming
                phase <= status_lnk[`EEP_ST_BUSY] ? eep_pkg::EEP_PH_END
                                                  : eep_pkg::EEP_PH_AHI;
              end
              `EEP_OP_STAT_RD: phase <= eep_pkg::EEP_PH_SRD;
              `EEP_OP_STAT_WR: phase <= eep_pkg::EEP_PH_SWR;
              default:         phase <= eep_pkg::EEP_PH_END;
            endcase
          end
          eep_pkg::EEP_PH_AHI: phase <= eep_pkg::EEP_PH_ALO;
          eep_pkg::EEP_PH_ALO: begin
            phase <= (instr == `EEP_OP_READ) ? eep_pkg::EEP_PH_RD
                                             : eep_pkg::EEP_PH_WR;
          end
          eep_pkg::EEP_PH_SWR: phase <= eep_pkg::EEP_PH_END;
          eep_pkg::EEP_PH_RD,
          eep_pkg::EEP_PH_WR,
          eep_pkg::EEP_PH_SRD,
          eep_pkg::EEP_PH_END: phase <= phase;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // instruction, address, page buffer, outcome
  // ---------------------------------------------------------------------------
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      instr     <= 8'h00;
      addr_hi   <= 3'h0;
      ptr       <= '0;
      off       <= '0;
      pg.base   <= '0;
      pg.mask   <= '0;
      stat_in   <= 8'h00;
      outcome   <= eep_pkg::EEP_OUT_NONE;
      frame_tog <= 1'b0;
      for (int i = 0; i < `EEP_PAGE_BYTES; i++) begin
        pg.data[i] <= 8'h00;
      end
    end else if (step) begin
      if (fresh) begin
        frame_tog <= ~frame_tog;
      end
      // any bit after a byte boundary cancels the pending outcome
      outcome <= eep_pkg::EEP_OUT_NONE;
      if (byte_done) begin
        unique case (phase)
          eep_pkg::EEP_PH_OP: begin
            instr <= rx_byte;
            if (rx_byte == `EEP_OP_SET_LATCH) begin
              outcome <= eep_pkg::EEP_OUT_SET;
            end else if (rx_byte == `EEP_OP_CLR_LATCH) begin
              outcome <= eep_pkg::EEP_OUT_CLR;
            end
          end
          eep_pkg::EEP_PH_AHI: addr_hi <= rx_byte[2:0];
          eep_pkg::EEP_PH_ALO: begin
            ptr     <= {addr_hi, rx_byte};
            off     <= rx_byte[`EEP_PAGE_BITS-1:0];
            pg.base <= {addr_hi, rx_byte[7:`EEP_PAGE_BITS]};
            pg.mask <= '0;
          end
          eep_pkg::EEP_PH_RD: ptr <= ptr + 11'h001;
          eep_pkg::EEP_PH_WR: begin
            pg.data[off] <= rx_byte;
            pg.mask[off] <= 1'b1;
            off          <= off + 1'b1;
            outcome      <= eep_pkg::EEP_OUT_WRITE;
          end
          eep_pkg::EEP_PH_SWR: begin
            stat_in <= rx_byte;
            outcome <= eep_pkg::EEP_OUT_STAT;
          end
          eep_pkg::EEP_PH_SRD,
          eep_pkg::EEP_PH_END: instr <= instr;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // serial output, launched on falling sck
  // ---------------------------------------------------------------------------
  assign pg.rd_addr = ptr;
  assign cur_byte = (phase == eep_pkg::EEP_PH_RD) ? pg.rd_data : status_lnk;

  always_ff @(negedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      so     <= 1'b0;
      out_sh <= 7'h00;
      oe_q   <= 1'b0;
    end else if (hold_n) begin
      oe_q <= (phase == eep_pkg::EEP_PH_RD) | (phase == eep_pkg::EEP_PH_SRD);
      if (phase == eep_pkg::EEP_PH_RD || phase == eep_pkg::EEP_PH_SRD) begin
        if (bit_cnt == 3'h0) begin
          so     <= cur_byte[7];
          out_sh <= cur_byte[6:0];
        end else begin
          so     <= out_sh[6];
          out_sh <= {out_sh[5:0], 1'b0};
        end
      end
    end
  end

  // hold floats so at once and drives the kept bit again on release
  assign so_oe = oe_q & hold_n;

  // ---------------------------------------------------------------------------
  // frame end detection (clk domain)
  // ---------------------------------------------------------------------------
  eep_sync #(.W(13)) u_link_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({cs_n, frame_tog, outcome, stat_in}),
    .q     (sync_q)
  );

  assign cs_s   = sync_q[12];
  assign tog_s  = sync_q[11];
  assign out_s  = eep_pkg::eep_outcome_e'(sync_q[10:8]);
  assign stat_s = sync_q[7:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_d     <= 1'b1;
      tog_seen <= 1'b0;
    end else begin
      cs_d <= cs_s;
      if (act) begin
        tog_seen <= tog_s;
      end
    end
  end

  // a frame with no sck edges leaves the toggle alone and does nothing
  assign act   = cs_s & ~cs_d & (tog_s != tog_seen);
  assign start = act & latch & ~busy
               & (out_s == eep_pkg::EEP_OUT_WRITE || out_s == eep_pkg::EEP_OUT_STAT);
  assign done  = busy & (tmr == 16'(TWC_CYCLES - 1));

  // ---------------------------------------------------------------------------
  // self-timed write cycle
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      tmr  <= 16'h0000;
    end else if (start) begin
      busy <= 1'b1;
      tmr  <= 16'h0000;
    end else if (done) begin
      busy <= 1'b0;
    end else if (busy) begin
      tmr <= tmr + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pg.commit <= 1'b0;
    end else begin
      pg.commit <= start & (out_s == eep_pkg::EEP_OUT_WRITE);
    end
  end

  // ---------------------------------------------------------------------------
  // write latch and status bits
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch <= 1'b0;
    end else if (act && out_s == eep_pkg::EEP_OUT_SET) begin
      latch <= 1'b1;
    end else if (done || (act && out_s == eep_pkg::EEP_OUT_CLR)) begin
      latch <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ppe   <= 1'(`EEP_STATUS_RST >> `EEP_ST_PPE);
      bp_hi <= 1'(`EEP_STATUS_RST >> `EEP_ST_BP_HI);
      bp_lo <= 1'(`EEP_STATUS_RST >> `EEP_ST_BP_LO);
    end else if (start && out_s == eep_pkg::EEP_OUT_STAT) begin
      ppe   <= stat_s[`EEP_ST_PPE];
      bp_hi <= stat_s[`EEP_ST_BP_HI];
      bp_lo <= stat_s[`EEP_ST_BP_LO];
    end
  end

  always_comb begin
    status                 = 8'h00;
    status[`EEP_ST_BUSY]   = busy;
    status[`EEP_ST_LATCH]  = latch;
    status[`EEP_ST_BP_LO]  = bp_lo;
    status[`EEP_ST_BP_HI]  = bp_hi;
    status[`EEP_ST_PPE]    = ppe;
  end

  // ---------------------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------------------
  eep_array u_array (
    .clk   (clk),
    .rst_n (rst_n),
    .pg    (pg.mem)
  );
endmodule : eep_top
`default_nettype wire

// File: eep_top_asserts.sv
// eep_top_asserts: port-level checks of the serial eeprom target.
// assumes the host moves si and hold_n only while sck is low.
`timescale 1ns/1ps
`default_nettype none
module eep_top_asserts #(
  parameter int TWC_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  input wire logic so,
  input wire logic so_oe
);
  // ---------------------------------------------------------------------
  // link-side bit count and captured opcode
  // ---------------------------------------------------------------------
  logic [5:0] cnt;
  logic [6:0] sr;
  logic [7:0] op;
  always_ff @(posedge sck or posedge cs_n or negedge rst_n) begin
    if (!rst_n || cs_n)
      cnt <= 6'h00;
    else if (hold_n && cnt != 6'h3F)
      cnt <= cnt + 6'h01;
  end
  always_ff @(posedge sck) begin
    if (hold_n && !cs_n)
      sr <= {sr[5:0], si};
  end
  always_ff @(posedge sck or posedge cs_n or negedge rst_n) begin
    if (!rst_n || cs_n)
      op <= 8'h00;
    else if (hold_n && cnt == 6'h07)
      op <= {sr, si};
  end
  // ---------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------
  property p_rst;
    @(posedge clk) !rst_n |-> !so_oe && !so;
  endproperty
  a_rst: assert property (p_rst) else $error("output active in reset");
  property p_desel;
    @(posedge clk) disable iff (!rst_n) $rose(cs_n) |-> !so_oe [*3];
  endproperty
  a_desel: assert property (p_desel) else $error("so driven while deselected");
  property p_hold;
    @(posedge clk) disable iff (!rst_n) !hold_n |-> !so_oe;
  endproperty
  a_hold: assert property (p_hold) else $error("so driven during hold");
  property p_pre_op;
    @(posedge sck) disable iff (!rst_n || cs_n) cnt < 6'd8 |-> !so_oe;
  endproperty
  a_pre_op: assert property (p_pre_op) else $error("so driven before opcode");
  property p_addr;
    @(posedge sck) disable iff (!rst_n || cs_n)
      op == 8'h03 && cnt >= 6'd8 && cnt < 6'd24 |-> !so_oe;
  endproperty
  a_addr: assert property (p_addr) else $error("so driven in address");
  property p_write;
    @(posedge sck) disable iff (!rst_n || cs_n) op == 8'h02 && cnt >= 6'd8 |-> !so_oe;
  endproperty
  a_write: assert property (p_write) else $error("so driven in write");
  property p_ctrl;
    @(posedge sck) disable iff (!rst_n || cs_n)
      op inside {8'h01, 8'h04, 8'h06} && cnt >= 6'd8 |-> !so_oe;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("so driven by control op");
  property p_unknown;
    @(posedge sck) disable iff (!rst_n || cs_n)
      cnt >= 6'd8 && !(op inside {[8'h01:8'h06]}) |-> !so_oe;
  endproperty
  a_unknown: assert property (p_unknown) else $error("so driven by unknown op");
  property p_status;
    @(posedge sck) disable iff (!rst_n || cs_n)
      op == 8'h05 && cnt >= 6'd8 && hold_n && $past(hold_n) |-> so_oe;
  endproperty
  a_status: assert property (p_status) else $error("status not driven");
  c_read: cover property (@(posedge sck) op == 8'h03 && cnt == 6'd24 && so_oe);
  c_status: cover property (@(posedge sck) op == 8'h05 && cnt == 6'd12 && so_oe);
  c_hold: cover property (@(posedge clk) $fell(hold_n) && !cs_n);
endmodule : eep_top_asserts
bind eep_top eep_top_asserts #(.TWC_CYCLES(TWC_CYCLES)) u_eep_top_asserts (
  .clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n),
  .so(so), .so_oe(so_oe));
`default_nettype wire

// File: tb.sv
// tb: self-checking bench for the serial eeprom target.
// assumes eep_top_asserts is bound and eep_spi_host drives the link.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic       clk;
  logic       rst_n;
  logic       sck;
  logic       cs_n;
  logic       si;
  logic       hold_n;
  logic       so;
  logic       so_oe;
  logic [7:0] rx;
  int         n_errors = 0;
  int         checked = 0;
  eep_top #(.TWC_CYCLES(80)) u_eep_top (.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n),
    .si(si), .hold_n(hold_n), .so(so), .so_oe(so_oe));
  eep_spi_host u_eep_spi_host (.clk(clk), .so(so), .so_oe(so_oe), .sck(sck), .cs_n(cs_n),
    .si(si), .hold_n(hold_n));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  task automatic summarize();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic op1(input logic [7:0] op);
    u_eep_spi_host.sel();
    u_eep_spi_host.xfer(op, 8, -1, rx);
    u_eep_spi_host.desel();
  endtask : op1
  task automatic hdr(input logic [7:0] op, input logic [15:0] a);
    u_eep_spi_host.sel();
    u_eep_spi_host.xfer(op, 8, -1, rx);
    u_eep_spi_host.xfer(a[15:8], 8, -1, rx);
    u_eep_spi_host.xfer(a[7:0], 8, -1, rx);
  endtask : hdr
  // status read, paused by hold in mid-byte
  task automatic stat(output logic [23:0] s);
    logic [7:0] b;
    u_eep_spi_host.sel();
    u_eep_spi_host.xfer(8'h05, 8, -1, rx);
    u_eep_spi_host.xfer(8'h00, 8, 3, b);
    u_eep_spi_host.desel();
    s = {16'h0000, b};
  endtask : stat
  task automatic rd3(input logic [15:0] a, output logic [23:0] d);
    hdr(8'h03, a);
    for (int i = 2; i >= 0; i--) begin
      u_eep_spi_host.xfer(8'h00, 8, (i == 1) ? 4 : -1, rx);
      d[i*8 +: 8] = rx;
    end
    u_eep_spi_host.desel();
  endtask : rd3
  task automatic wait_idle();
    logic [23:0] s;
    for (int i = 0; i < 20; i++) begin
      stat(s);
      if (s[0] === 1'b0)
        return;
    end
    n_errors++;
    $display("FAIL t=%0t busy stuck got=%h exp=%h", $time, s, 24'h0);
    summarize();
  endtask : wait_idle
  // ---------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------
  task automatic t_idle();
    logic [23:0] s;
    stat(s);
    chk(s, 24'h000000);
    op1(8'hFF);
    hdr(8'h02, 16'h0010);
    u_eep_spi_host.xfer(8'h5A, 8, -1, rx);
    u_eep_spi_host.desel();
    rd3(16'hF810, s);
    chk(s, 24'hFFFFFF);
    $display("t_idle done");
  endtask : t_idle
  task automatic t_page();
    logic [23:0] s;
    op1(8'h06);
    stat(s);
    chk(s, 24'h000002);
    hdr(8'h02, 16'h07FE);
    u_eep_spi_host.xfer(8'hA1, 8, -1, rx);
    u_eep_spi_host.xfer(8'hB2, 8, -1, rx);
    u_eep_spi_host.xfer(8'hC3, 8, -1, rx);
    u_eep_spi_host.desel();
    stat(s);
    chk(s, 24'h000003);
    rd3(16'h07FE, s);
    chk(s, 24'hFFFFFF);
    wait_idle();
    stat(s);
    chk(s, 24'h000000);
    rd3(16'h07FE, s);
    chk(s, 24'hA1B2FF);
    rd3(16'h07E0, s);
    chk(s, 24'hC3FFFF);
    $display("t_page done");
  endtask : t_page
  task automatic t_latch();
    logic [23:0] s;
    hdr(8'h06, 16'h0200);
    u_eep_spi_host.xfer(8'h10, 8, -1, rx);
    u_eep_spi_host.xfer(8'h5A, 8, -1, rx);
    u_eep_spi_host.desel();
    stat(s);
    chk(s, 24'h000000);
    op1(8'h06);
    op1(8'h04);
    stat(s);
    chk(s, 24'h000000);
    op1(8'h06);
    hdr(8'h02, 16'h0010);
    u_eep_spi_host.xfer(8'h5A, 4, -1, rx);
    u_eep_spi_host.desel();
    stat(s);
    chk(s, 24'h000002);
    rd3(16'h0010, s);
    chk(s, 24'hFFFFFF);
    $display("t_latch done");
  endtask : t_latch
  task automatic t_swr();
    logic [23:0] s;
    u_eep_spi_host.sel();
    u_eep_spi_host.xfer(8'h01, 8, -1, rx);
    u_eep_spi_host.xfer(8'h8C, 8, -1, rx);
    u_eep_spi_host.desel();
    wait_idle();
    stat(s);
    chk(s, 24'h00008C);
    $display("t_swr done");
  endtask : t_swr
  initial begin
    rst_n = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_idle();
    t_page();
    t_latch();
    t_swr();
    summarize();
  end
  initial begin
    #2ms;
    n_errors++;
    $display("FAIL t=%0t timeout got=%h exp=%h", $time, 1'b0, 1'b1);
    summarize();
  end
endmodule : tb
`default_nettype wire
